// ==== verilog/rss_pkg.sv ====
// Package for the rail strobe sequencer: register map, field layout,
// reset values, timing counts and sequencer states.
// Assumes a 50 MHz core clock shared by every file that imports it.
package rss_pkg;

  // Register offsets on the device register port
  localparam logic [7:0] RSS_OFS_DELAY_SELECT = 8'h20;
  localparam logic [7:0] RSS_OFS_DELAY_FACTOR = 8'h21;
  localparam logic [7:0] RSS_OFS_STROBE_ASSIGN = 8'h22;

  // Reset values
  localparam logic [7:0] RSS_RST_DELAY_SELECT = 8'h00;
  localparam logic [7:0] RSS_RST_DELAY_FACTOR = 8'h00;
  localparam logic [7:0] RSS_RST_STROBE_ASSIGN = 8'h56;

  // Field positions
  localparam int RSS_POS_STRETCH = 7;
  localparam int RSS_POS_GAP_NINE = 0;
  localparam int RSS_POS_BUCK_TWO_LSB = 4;
  localparam int RSS_POS_BUCK_ONE_LSB = 0;

  // Strobe numbering and sequencer-controlled code range
  localparam logic [3:0] RSS_STROBE_FIRST = 4'h1;
  localparam logic [3:0] RSS_STROBE_LAST = 4'hA;
  localparam logic [3:0] RSS_SLOT_MIN = 4'h3;
  localparam logic [3:0] RSS_SLOT_MAX = 4'hA;

  // Timing: 1 ms tick from the 50 MHz clock, gap lengths in ms
  localparam int RSS_CLK_HZ = 50_000_000;
  localparam int RSS_TICK_US = 1000;
  localparam int RSS_TICK_CYCLES = RSS_CLK_HZ / 1_000_000 * RSS_TICK_US;
  localparam int RSS_GAP_SHORT_MS = 2;
  localparam int RSS_GAP_LONG_MS = 5;
  localparam int RSS_STRETCH_FACTOR = 10;

  typedef enum logic [1:0] {
    RSS_IDLE,
    RSS_UP,
    RSS_DOWN
  } rss_state_type;

endpackage : rss_pkg

// ==== verilog/rss_tick.sv ====
// Millisecond tick divider for the rail strobe sequencer.
// Assumes the 50 MHz core clock; emits a one-cycle enable every TICK_CYCLES
// clocks, which is 1 ms by default.
`timescale 1ns/10ps
module rss_tick
  import rss_pkg::*;
#(
  parameter int TICK_CYCLES = RSS_TICK_CYCLES
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic run,
  output logic tick
);

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

  logic [15:0] count_q;

  // Count only while a sequence runs so each walk starts on a fresh phase
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= 16'h0000;
      tick <= 1'b0;
    end else if (!run) begin
      count_q <= 16'h0000;
      tick <= 1'b0;
    end else if (count_q == TICK_LAST) begin
      count_q <= 16'h0000;
      tick <= 1'b1;
    end else begin
      count_q <= count_q + 16'h0001;
      tick <= 1'b0;
    end
  end

endmodule : rss_tick

// ==== verilog/rss_sequencer.sv ====
// Rail strobe sequencer: three sequence registers on the device register
// port, strobe walker with programmable gaps, and the two step-down
// rail enables. Register port writes land only while the device's unlock
// logic holds reg_unlocked high; inputs are assumed synchronous.
// TICK_CYCLES sets the 1 ms tick; it is lowered only to shorten simulation.
`timescale 1ns/10ps
module rss_sequencer
  import rss_pkg::*;
#(
  parameter int TICK_CYCLES = RSS_TICK_CYCLES
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic reg_unlocked,
  input wire logic power_up_req,
  input wire logic power_down_req,
  output logic [7:0] reg_rdata,
  output logic first_stepdown_rail,
  output logic second_stepdown_rail,
  output logic [3:0] active_strobe,
  output logic seq_busy
);

  // Gap lengths in ms ticks, wide enough for the stretched 50 ms gap
  localparam logic [9:0] GAP_SHORT = 10'(RSS_GAP_SHORT_MS);
  localparam logic [9:0] GAP_LONG = 10'(RSS_GAP_LONG_MS);
  localparam logic [9:0] GAP_MULT = 10'(RSS_STRETCH_FACTOR);

  // Stored register fields
  logic [7:0] delay_select_q;
  logic stretch_q;
  logic gap_nine_q;
  logic [7:0] strobe_assign_q;

  // Walker state and the ms tick that paces it
  rss_state_type state_q;
  logic [3:0] strobe_q;
  logic [9:0] wait_q;
  logic tick;
  logic walk_run;

  // Decoded views of the register fields
  logic [15:0] gap_sel;
  logic [9:0] gap_len;
  logic [3:0] buck_one_slot;
  logic [3:0] buck_two_slot;
  logic wr_ok;

  // Slot code decoding is shared by both rails
  function automatic logic slot_valid(input logic [3:0] code);
    slot_valid = (code >= RSS_SLOT_MIN) && (code <= RSS_SLOT_MAX);
  endfunction : slot_valid

  // A rail fires only at its own strobe, and only for a controlled code
  function automatic logic slot_fires(input logic [3:0] code, input logic [3:0] strobe);
    slot_fires = slot_valid(code) && (strobe == code);
  endfunction : slot_fires

  // Base gap length for one selector bit
  function automatic logic [9:0] gap_base(input logic long_sel);
    gap_base = long_sel ? GAP_LONG : GAP_SHORT;
  endfunction : gap_base

  assign wr_ok = reg_write && reg_unlocked;
  assign buck_one_slot = strobe_assign_q[RSS_POS_BUCK_ONE_LSB +: 4];
  assign buck_two_slot = strobe_assign_q[RSS_POS_BUCK_TWO_LSB +: 4];
  // Upper selector bits are padded so any strobe index stays in range
  assign gap_sel = {7'h00, gap_nine_q, delay_select_q};
  assign walk_run = (state_q != RSS_IDLE);

  // Gap length for the current strobe; in power-down the gap after strobe n
  // counts toward strobe n-1, so the selector below the strobe is used
  always_comb begin
    logic [3:0] idx;
    idx = 4'h0;
    if (state_q == RSS_DOWN) begin
      idx = strobe_q - 4'h2;
    end else begin
      idx = strobe_q - 4'h1;
    end
    gap_len = gap_base(gap_sel[idx]);
    if (state_q == RSS_DOWN && stretch_q) begin
      gap_len = 10'(gap_len * GAP_MULT);
    end
  end

  // Gap selectors for strobes 1 to 8; a locked write never lands
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      delay_select_q <= RSS_RST_DELAY_SELECT;
    end else if (wr_ok && reg_addr == RSS_OFS_DELAY_SELECT) begin
      delay_select_q <= reg_wdata;
    end
  end

  // Stretch and ninth gap bits; the six reserved bits are never stored
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stretch_q <= RSS_RST_DELAY_FACTOR[RSS_POS_STRETCH];
      gap_nine_q <= RSS_RST_DELAY_FACTOR[RSS_POS_GAP_NINE];
    end else if (wr_ok && reg_addr == RSS_OFS_DELAY_FACTOR) begin
      stretch_q <= reg_wdata[RSS_POS_STRETCH];
      gap_nine_q <= reg_wdata[RSS_POS_GAP_NINE];
    end
  end

  // Rail slot fields; a code written mid-walk applies from the next strobe match
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      strobe_assign_q <= RSS_RST_STROBE_ASSIGN;
    end else if (wr_ok && reg_addr == RSS_OFS_STROBE_ASSIGN) begin
      strobe_assign_q <= reg_wdata;
    end
  end

  // Read data is registered; unmapped offsets and reserved bits read zero
  // A read leaves the registers untouched; only the last read value is held
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        RSS_OFS_DELAY_SELECT: reg_rdata <= delay_select_q;
        RSS_OFS_DELAY_FACTOR: reg_rdata <= {stretch_q, 6'h00, gap_nine_q};
        RSS_OFS_STROBE_ASSIGN: reg_rdata <= strobe_assign_q;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // The ms tick runs only during a walk, so every walk starts on the same phase
  rss_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clock(clock),
    .rst_n(rst_n),
    .run(walk_run),
    .tick(tick)
  );

  // Strobe walker: a strobe fires on entry, then its gap runs in ms ticks.
  // Requests during a walk are ignored to keep the rail order consistent.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= RSS_IDLE;
      strobe_q <= 4'h0;
      wait_q <= 10'h000;
    end else begin
      case (state_q)
        RSS_IDLE: begin
          wait_q <= 10'h000;
          // Up wins when both requests arrive in the same cycle
          if (power_up_req) begin
            state_q <= RSS_UP;
            strobe_q <= RSS_STROBE_FIRST;
          end else if (power_down_req) begin
            state_q <= RSS_DOWN;
            strobe_q <= RSS_STROBE_LAST;
          end
        end
        RSS_UP, RSS_DOWN: begin
          // The last strobe of either direction ends the walk with no gap after it
          if (state_q == RSS_UP && strobe_q == RSS_STROBE_LAST) begin
            state_q <= RSS_IDLE; // No gap follows the last strobe
            strobe_q <= 4'h0;
          end else if (state_q == RSS_DOWN && strobe_q == RSS_STROBE_FIRST) begin
            state_q <= RSS_IDLE;
            strobe_q <= 4'h0;
          end else if (tick) begin
            // Whole ms ticks only; the first tick of a walk lands one clock late
            if (wait_q + 10'h001 >= gap_len) begin
              wait_q <= 10'h000;
              strobe_q <= (state_q == RSS_UP) ? strobe_q + 4'h1 : strobe_q - 4'h1;
            end else begin
              wait_q <= wait_q + 10'h001;
            end
          end
        end
        default: state_q <= RSS_IDLE;
      endcase
    end
  end

  // Rail enables follow strobes; rails with an out-of-range code keep state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      first_stepdown_rail <= 1'b0;
      second_stepdown_rail <= 1'b0;
    end else if (walk_run) begin
      if (slot_fires(buck_one_slot, strobe_q)) begin
        first_stepdown_rail <= (state_q == RSS_UP);
      end
      if (slot_fires(buck_two_slot, strobe_q)) begin
        second_stepdown_rail <= (state_q == RSS_UP);
      end
    end
  end

  // Status outputs registered, so they trail the walker by one clock
  // and stay free of decode glitches
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      active_strobe <= 4'h0;
      seq_busy <= 1'b0;
    end else begin
      active_strobe <= strobe_q;
      seq_busy <= walk_run;
    end
  end

endmodule : rss_sequencer

// ==== tb/rss_chk.sv ====
// Port checker for rss_sequencer.
// Assumes the 50 MHz clock and the 1 ms gap tick.
`timescale 1ns/10ps
module rss_chk
  import rss_pkg::*;
#(
  parameter int TICK_CYCLES = RSS_TICK_CYCLES
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic reg_unlocked,
  input wire logic power_up_req,
  input wire logic power_down_req,
  input wire logic [7:0] reg_rdata,
  input wire logic first_stepdown_rail,
  input wire logic second_stepdown_rail,
  input wire logic [3:0] active_strobe,
  input wire logic seq_busy
);
  logic [7:0] slots_q;
  logic [21:0] gap_q;
  // Shortest and longest strobe spacing in cycles, tick phase included
  localparam logic [21:0] GAP_FLOOR = 22'(RSS_GAP_SHORT_MS * TICK_CYCLES - 1);
  localparam logic [21:0] GAP_CEIL = 22'(RSS_STRETCH_FACTOR * RSS_GAP_LONG_MS * TICK_CYCLES + 2);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Shadow of the slot register, so rail edges can be tied to a slot
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) slots_q <= 8'h56;
    else if (reg_write && reg_unlocked && reg_addr == 8'h22) slots_q <= reg_wdata;
  end
  // Cycles since the strobe moved; saturates so long idle spans never wrap
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) gap_q <= 22'h00_0000;
    else if ($changed(active_strobe)) gap_q <= 22'h00_0000;
    else if (gap_q != 22'h3F_FFFF) gap_q <= gap_q + 22'h00_0001;
  end
  sequence strobe_moves;
    $changed(active_strobe) && active_strobe != 4'h0 && $past(active_strobe) != 4'h0;
  endsequence
  AST_RD_RESERVED: assert property (reg_read && reg_addr == 8'h21 |=>
    reg_rdata[6:1] == 6'h00) else $error("reserved bits read nonzero");
  AST_RD_HOLD: assert property (!reg_read |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  AST_STEP_ONE: assert property (strobe_moves |->
    active_strobe == $past(active_strobe) + 4'h1 || active_strobe == $past(active_strobe) - 4'h1)
    else $error("strobe skipped a number");
  AST_GAP_MIN: assert property (strobe_moves |-> gap_q >= GAP_FLOOR)
    else $error("strobe gap shorter than 2 ms");
  AST_GAP_MAX: assert property (seq_busy && $past(seq_busy) |-> gap_q <= GAP_CEIL)
    else $error("strobe gap longer than 50 ms");
  AST_RANGE: assert property (active_strobe <= 4'hA)
    else $error("strobe number above 10");
  AST_BUSY_STROBE: assert property (seq_busy == (active_strobe != 4'h0))
    else $error("busy flag and strobe number disagree");
  AST_FIRST_SLOT: assert property ($rose(first_stepdown_rail) |->
    active_strobe == slots_q[3:0]) else $error("first rail rose off its slot");
  AST_SECOND_SLOT: assert property ($changed(second_stepdown_rail) |->
    active_strobe == slots_q[7:4]) else $error("second rail moved off its slot");
  AST_CODE_RANGE: assert property ($changed(first_stepdown_rail) |->
    slots_q[3:0] >= 4'h3 && slots_q[3:0] <= 4'hA) else $error("uncontrolled rail moved");
endmodule : rss_chk
bind rss_sequencer rss_chk #(.TICK_CYCLES(TICK_CYCLES)) i_rss_chk (.clock(clock),
  .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .reg_read(reg_read),
  .reg_unlocked(reg_unlocked), .power_up_req(power_up_req), .power_down_req(power_down_req),
  .reg_rdata(reg_rdata), .first_stepdown_rail(first_stepdown_rail),
  .second_stepdown_rail(second_stepdown_rail), .active_strobe(active_strobe),
  .seq_busy(seq_busy));

// ==== tb/rss_rail_model.sv ====
// Regulator enable input: counts turn-on edges of one rail.
// Assumes the enable is registered on the same clock.
`timescale 1ns/10ps
module rss_rail_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic rail_en,
  output logic [7:0] turn_ons
);
  logic en_q;
  // A rail that glitches on twice shows up as an extra count
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= 1'b0;
      turn_ons <= 8'h00;
    end else begin
      en_q <= rail_en;
      if (rail_en && !en_q) turn_ons <= turn_ons + 8'h01;
    end
  end
endmodule : rss_rail_model

// ==== tb/rss_sequencer_bench.sv ====
// Bench for rss_sequencer: register port, up and down walks, mid-walk reset.
// Runs the design with a 50-clock ms tick so every walk stays short.
`timescale 1ns/10ps
module rss_sequencer_bench;
  logic clock, rst_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0, reg_unlocked = 1'b1;
  logic power_up_req = 1'b0, power_down_req = 1'b0, rail1, rail2, seq_busy;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, ons1, ons2;
  logic [3:0] active_strobe;
  int errors = 0, total_checks = 0, cyc;
  localparam int TICK = 50;
  rss_sequencer #(.TICK_CYCLES(TICK)) i_rss_sequencer (.clock(clock), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_unlocked(reg_unlocked), .power_up_req(power_up_req),
    .power_down_req(power_down_req), .reg_rdata(reg_rdata), .first_stepdown_rail(rail1),
    .second_stepdown_rail(rail2), .active_strobe(active_strobe), .seq_busy(seq_busy));
  rss_rail_model i_rail_one (.clock(clock), .rst_n(rst_n), .rail_en(rail1), .turn_ons(ons1));
  rss_rail_model i_rail_two (.clock(clock), .rst_n(rst_n), .rail_en(rail2), .turn_ons(ons2));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic u);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_unlocked = u;
    reg_write = 1'b1;
    @(negedge clock);
    reg_write = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clock);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clock);
    reg_read = 1'b0;
    chk(reg_rdata, exp);
  endtask : rd
  // Bounded wait for a strobe number; cyc keeps the cycles spent, a timeout mismatches
  task automatic wait_strobe(input logic [3:0] n);
    cyc = 0;
    while (active_strobe !== n && cyc < 300 * TICK) begin
      @(negedge clock);
      cyc++;
    end
    chk({4'h0, active_strobe}, {4'h0, n});
  endtask : wait_strobe
  // One-clock walk request, up or down
  task automatic pulse_req(input logic up);
    @(negedge clock);
    power_up_req = up;
    power_down_req = !up;
    @(negedge clock);
    power_up_req = 1'b0;
    power_down_req = 1'b0;
  endtask : pulse_req
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  // Watchdog: all walks together need about 15,000 clocks, so 50,000 is ample
  initial begin
    #1_000_000;
    errors++;
    close_out();
  end
  initial begin
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    rd(8'h20, 8'h00);
    rd(8'h21, 8'h00);
    rd(8'h22, 8'h56);
    wr(8'h21, 8'hFF, 1'b1);
    rd(8'h21, 8'h81);
    wr(8'h20, 8'hFF, 1'b0);
    rd(8'h20, 8'h00);
    rd(8'h30, 8'h00);
    wr(8'h20, 8'h04, 1'b1);
    wr(8'h22, 8'hB3, 1'b1);
    rd(8'h22, 8'hB3);
    // Up walk with stretch set: the 5 ms gap after strobe 3 must not grow
    pulse_req(1'b1);
    wait_strobe(4'h3);
    chk({7'h00, rail1}, 8'h01);
    wait_strobe(4'h4);
    chk({7'h00, cyc >= 5 * TICK - 2 && cyc <= 5 * TICK + 3}, 8'h01);
    wait_strobe(4'h0);
    chk({6'h00, rail2, rail1}, 8'h01);
    chk(ons2, 8'h00);
    // Down walk: first gap uses the ninth selector (5 ms), stretched tenfold
    pulse_req(1'b0);
    wait_strobe(4'hA);
    wait_strobe(4'h9);
    chk({7'h00, cyc >= 50 * TICK - 2 && cyc <= 50 * TICK + 3}, 8'h01);
    wait_strobe(4'h0);
    chk({6'h00, rail2, rail1}, 8'h00);
    chk(ons1, 8'h01);
    // Reset in the middle of an up walk drops every output
    pulse_req(1'b1);
    wait_strobe(4'h4);
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    chk({3'h0, seq_busy, active_strobe}, 8'h00);
    chk({6'h00, rail2, rail1}, 8'h00);
    rst_n = 1'b1;
    rd(8'h22, 8'h56);
    rd(8'h21, 8'h00);
    // Default slots: second rail at strobe 5, first rail at strobe 6
    pulse_req(1'b1);
    wait_strobe(4'h5);
    chk({6'h00, rail2, rail1}, 8'h02);
    wait_strobe(4'h6);
    chk({6'h00, rail2, rail1}, 8'h03);
    wait_strobe(4'h0);
    // Unstretched down walk: the gap after strobe 10 stays 2 ms
    pulse_req(1'b0);
    wait_strobe(4'hA);
    wait_strobe(4'h9);
    chk({7'h00, cyc >= 2 * TICK - 2 && cyc <= 2 * TICK + 3}, 8'h01);
    wait_strobe(4'h0);
    chk({6'h00, rail2, rail1}, 8'h00);
    chk({ons2[3:0], ons1[3:0]}, 8'h11);
    close_out();
  end
endmodule : rss_sequencer_bench
